// *** rtl/ssef_pkg.sv ***
// Package of constants and types for the serial encoder feedback and simulated output block
package ssef_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TURNS = 8'h04;
    localparam logic [7:0] REG_LINES = 8'h08;
    localparam logic [7:0] REG_DIVIDER = 8'h0C;
    localparam logic [7:0] REG_SIM_SRC = 8'h10;
    localparam logic [7:0] REG_SIM_NUM = 8'h14;
    localparam logic [7:0] REG_SIM_DEN = 8'h18;
    localparam logic [7:0] REG_EFF_LINES = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_POSITION = 8'h24;
    localparam logic [7:0] REG_COMMS_RES = 8'h28;
    localparam logic [7:0] REG_CMD = 8'h2C;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // Reset values
    localparam logic [15:0] SIM_SCALE_RST = 16'h0001;
    localparam logic [5:0] TURNS_RST = 6'h00;
    localparam logic [5:0] COMMS_RES_RST = 6'h19;
    localparam logic [19:0] LINES_RST = 20'h00400;
    localparam logic [15:0] DIVIDER_RST = 16'h0001;
    // Source index limits (menu.parameter) and turn-bit limit
    localparam logic [4:0] MENU_MAX = 5'h15;
    localparam logic [5:0] PARAM_MAX = 6'h33;
    localparam logic [5:0] MAX_TURN_BITS = 6'h10;
    // Feedback types and simulated output modes
    localparam logic [1:0] FB_QUAD = 2'h0;
    localparam logic [1:0] FB_FREQ_DIR = 2'h1;
    localparam logic [1:0] FB_FWD_REV = 2'h2;
    localparam logic [1:0] FB_SINCOS = 2'h3;
    localparam logic [1:0] SIM_QUAD = 2'h0;
    localparam logic [1:0] SIM_FREQ_DIR = 2'h1;
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_HZ [5] = '{100_000, 250_000, 500_000, 1_000_000, 2_000_000};
    localparam int SIN_MAX_HZ = 166_000;
    localparam int SIN_MIN_PERIOD = (CLK_HZ + SIN_MAX_HZ - 1) / SIN_MAX_HZ;
    localparam int COL_HZ [3] = '{50_000, 100_000, 150_000};
    localparam int QUAD_STEP_NS = 100;
    localparam int QUAD_STEP_CYC = QUAD_STEP_NS * (CLK_HZ / 1_000_000) / 1000;
    // Configuration carried from the control register
    typedef struct packed {
        logic [2:0] baud;
        logic [1:0] fb_type;
        logic [1:0] sim_mode;
        logic binary;
    } ssef_cfg_s;
    typedef enum logic [1:0] {LINK_IDLE, LINK_SHIFT, LINK_DONE} ssef_link_e;
endpackage : ssef_pkg

// *** rtl/ssef_top.sv ***
// Serial absolute encoder feedback with scaled simulated encoder output
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
module ssef_top
    import ssef_pkg::*;
#(
    parameter int AW = 8,
    parameter int STEP_CYC = QUAD_STEP_CYC
) (
    input wire logic CLK, // System clock
    input wire logic SRST, // Synchronous reset, high
    input wire logic [AW-1:0] AWADDR, // Write address
    input wire logic AWVALID, // Write address valid
    output logic AWREADY, // Write address ready
    input wire logic [31:0] WDATA, // Write data
    input wire logic [3:0] WSTRB, // Write strobes
    input wire logic WVALID, // Write data valid
    output logic WREADY, // Write data ready
    output logic [1:0] BRESP, // Write response
    output logic BVALID, // Write response valid
    input wire logic BREADY, // Write response ready
    input wire logic [AW-1:0] ARADDR, // Read address
    input wire logic ARVALID, // Read address valid
    output logic ARREADY, // Read address ready
    output logic [31:0] RDATA, // Read data
    output logic [1:0] RRESP, // Read response
    output logic RVALID, // Read data valid
    input wire logic RREADY, // Read data ready
    output logic ENC_CLK, // Serial encoder clock
    input wire logic ENC_DATA, // Serial encoder data
    input wire logic SIN_SQ, // Squared sine track
    input wire logic [2:0] AMP_LEVEL, // Sine amplitude row, 0 largest
    output logic [10:0] SRC_SEL, // Selected drive parameter index
    input wire logic [15:0] SRC_VALUE, // Value of selected drive parameter
    output logic SIM_A, // Simulated output channel A
    output logic SIM_B // Simulated output channel B
);
    // Gray to binary, prefix xor from the top
    function automatic logic [31:0] gray2bin(input logic [31:0] g);
        logic [31:0] b;
        b[31] = g[31];
        for (int i = 30; i >= 0; i--) b[i] = b[i+1] ^ g[i];
        return b;
    endfunction : gray2bin

    // Bits needed to count a value
    function automatic logic [5:0] bits_of(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) if (v[i]) n = 6'(i + 1);
        return n;
    endfunction : bits_of

    // Interpolation bits by amplitude row and frequency column
    function automatic logic [3:0] interp_bits(input logic [2:0] row, input logic [2:0] col);
        logic [3:0] t [5][5];
        t = '{'{4'hB, 4'hB, 4'hB, 4'hA, 4'hA}, '{4'hB, 4'hB, 4'hA, 4'hA, 4'h9},
              '{4'hA, 4'hA, 4'hA, 4'hA, 4'h9}, '{4'hA, 4'hA, 4'hA, 4'h9, 4'h9},
              '{4'h9, 4'h9, 4'h9, 4'h9, 4'h8}};
        return t[(row > 3'h4) ? 3'h4 : row][(col > 3'h4) ? 3'h4 : col];
    endfunction : interp_bits

    ssef_cfg_s cfg_reg;
    logic [5:0] turns_reg, comms_res_reg;
    logic [19:0] lines_reg;
    logic [15:0] divider_reg, num_reg, den_reg;
    logic own_src_reg;
    logic [31:0] eff_lines_reg, word_reg;
    logic [AW-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic aw_have_reg, w_have_reg, start_reg;

    // Write channel: address and data taken in either order
    wire wr_fire = aw_have_reg && w_have_reg && !BVALID;
    wire [7:0] wa = 8'(aw_addr_reg);
    wire [7:0] ra = 8'(ARADDR);
    wire wa_ok = wa == REG_CTRL || wa == REG_TURNS || wa == REG_LINES || wa == REG_DIVIDER
        || wa == REG_SIM_SRC || wa == REG_SIM_NUM || wa == REG_SIM_DEN || wa == REG_COMMS_RES
        || wa == REG_CMD;
    logic [3:0] wstrb_reg;
    wire wr_on = wr_fire && wa_ok && (&wstrb_reg);
    wire src_ok = w_data_reg[12:8] <= MENU_MAX && w_data_reg[5:0] <= PARAM_MAX;
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= RESP_OK;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            wstrb_reg <= 4'h0;
        end
        else
        begin
            if (AWVALID && AWREADY)
            begin
                aw_addr_reg <= AWADDR;
                aw_have_reg <= 1'b1;
                AWREADY <= 1'b0;
            end
            if (WVALID && WREADY)
            begin
                w_data_reg <= WDATA;
                wstrb_reg <= WSTRB;
                w_have_reg <= 1'b1;
                WREADY <= 1'b0;
            end
            if (wr_fire)
            begin
                BVALID <= 1'b1;
                BRESP <= wa_ok ? RESP_OK : RESP_ERR;
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
            end
            if (BVALID && BREADY)
            begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    // Configuration registers; partial-strobe writes are ignored to keep fields whole
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            cfg_reg <= '0;
            turns_reg <= TURNS_RST;
            lines_reg <= LINES_RST;
            divider_reg <= DIVIDER_RST;
            num_reg <= SIM_SCALE_RST;
            den_reg <= SIM_SCALE_RST;
            own_src_reg <= 1'b1;
            SRC_SEL <= '0;
            comms_res_reg <= COMMS_RES_RST;
            start_reg <= 1'b0;
        end
        else
        begin
            start_reg <= wr_on && wa == REG_CMD && w_data_reg[0];
            if (wr_on && wa == REG_CTRL) cfg_reg <= ssef_cfg_s'(w_data_reg[7:0]);
            else if (wr_on && wa == REG_TURNS)
                turns_reg <= (w_data_reg[5:0] > MAX_TURN_BITS) ? MAX_TURN_BITS : w_data_reg[5:0];
            else if (wr_on && wa == REG_LINES) lines_reg <= w_data_reg[19:0];
            else if (wr_on && wa == REG_DIVIDER) divider_reg <= w_data_reg[15:0];
            else if (wr_on && wa == REG_SIM_NUM) num_reg <= w_data_reg[15:0];
            else if (wr_on && wa == REG_SIM_DEN) den_reg <= w_data_reg[15:0];
            else if (wr_on && wa == REG_COMMS_RES) comms_res_reg <= w_data_reg[5:0];
            else if (wr_on && wa == REG_SIM_SRC && src_ok)
            begin
                own_src_reg <= w_data_reg[16];
                SRC_SEL <= {w_data_reg[12:8], w_data_reg[5:0]};
            end
        end
    end

    // Equivalent and effective lines, zero divider taken as one
    wire [19:0] equiv_lines = (cfg_reg.fb_type == FB_FREQ_DIR || cfg_reg.fb_type == FB_FWD_REV)
        ? (lines_reg >> 1) : lines_reg;
    wire [15:0] div_safe = (divider_reg == 16'h0000) ? DIVIDER_RST : divider_reg;
    always_ff @(posedge CLK)
    begin
        if (SRST) eff_lines_reg <= '0;
        else eff_lines_reg <= 32'(equiv_lines / div_safe);
    end

    // Sine track and encoder data synchronisers; second and third stage must agree
    logic [2:0] sin_sync_reg, dat_sync_reg;
    logic sin_lvl_reg, dat_lvl_reg, overspeed_reg;
    logic [15:0] sin_cnt_reg, sin_per_reg;
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sin_sync_reg <= 3'h0;
            dat_sync_reg <= 3'h0;
            sin_lvl_reg <= 1'b0;
            dat_lvl_reg <= 1'b0;
        end
        else
        begin
            sin_sync_reg <= {sin_sync_reg[1:0], SIN_SQ};
            dat_sync_reg <= {dat_sync_reg[1:0], ENC_DATA};
            if (sin_sync_reg[1] == sin_sync_reg[2]) sin_lvl_reg <= sin_sync_reg[2];
            if (dat_sync_reg[1] == dat_sync_reg[2]) dat_lvl_reg <= dat_sync_reg[2];
        end
    end

    // Sine period measured rising to rising
    wire sin_rise = sin_sync_reg[1] == sin_sync_reg[2] && sin_sync_reg[2] && !sin_lvl_reg;
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sin_cnt_reg <= '0;
            sin_per_reg <= '1;
            overspeed_reg <= 1'b0;
        end
        else if (sin_rise)
        begin
            sin_cnt_reg <= '0;
            sin_per_reg <= sin_cnt_reg;
            overspeed_reg <= 32'(sin_cnt_reg) < SIN_MIN_PERIOD;
        end
        else if (sin_cnt_reg != 16'hFFFF) sin_cnt_reg <= sin_cnt_reg + 16'h0001;
    end

    // Frequency column from period; higher frequency gives fewer bits
    wire [2:0] col = (32'(sin_per_reg) >= CLK_HZ / COL_HZ[0]) ? 3'h0
        : (32'(sin_per_reg) >= CLK_HZ / COL_HZ[1]) ? 3'h2
        : (32'(sin_per_reg) >= CLK_HZ / COL_HZ[2]) ? 3'h3 : 3'h4;
    wire [3:0] ibits = interp_bits(AMP_LEVEL, col);
    wire [6:0] total_bits = 7'(bits_of(eff_lines_reg)) + 7'(ibits);

    // Serial link: half-period tick from the baud list
    ssef_link_e link_reg;
    logic [15:0] half_cnt_reg;
    logic [5:0] bit_cnt_reg;
    logic [31:0] shift_reg;
    wire [15:0] half_cyc = (cfg_reg.baud > 3'h4) ? 16'(CLK_HZ / (2 * BAUD_HZ[4]))
        : 16'(CLK_HZ / (2 * BAUD_HZ[cfg_reg.baud]));
    wire half_tick = half_cnt_reg >= half_cyc - 16'h0001;
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            link_reg <= LINK_IDLE;
            ENC_CLK <= 1'b1;
            half_cnt_reg <= '0;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
        end
        else
        begin
            case (link_reg)
                LINK_IDLE:
                begin
                    ENC_CLK <= 1'b1;
                    half_cnt_reg <= '0;
                    bit_cnt_reg <= '0;
                    if (start_reg && comms_res_reg != 6'h00) link_reg <= LINK_SHIFT;
                end
                LINK_SHIFT:
                begin
                    half_cnt_reg <= half_tick ? 16'h0000 : half_cnt_reg + 16'h0001;
                    if (half_tick)
                    begin
                        ENC_CLK <= !ENC_CLK;
                        if (!ENC_CLK) // Rising edge: encoder has had a half period to settle
                        begin
                            shift_reg <= {shift_reg[30:0], dat_lvl_reg};
                            bit_cnt_reg <= bit_cnt_reg + 6'h01;
                            if (bit_cnt_reg + 6'h01 == comms_res_reg) link_reg <= LINK_DONE;
                        end
                    end
                end
                LINK_DONE: link_reg <= LINK_IDLE;
                default: link_reg <= LINK_IDLE;
            endcase
        end
    end

    // Decoded word; bits above the comms width are zero so Gray decode is exact
    wire [31:0] raw_word = shift_reg & ((32'h1 << comms_res_reg) - 32'h1);
    wire [31:0] dec_word = cfg_reg.binary ? raw_word : gray2bin(raw_word);
    wire [5:0] st_bits = (comms_res_reg > turns_reg) ? comms_res_reg - turns_reg : 6'h00;
    wire [15:0] turn_mask = 16'((32'h1 << turns_reg) - 32'h1);
    wire [15:0] rev_count = 16'(word_reg >> st_bits) & turn_mask;
    wire [31:0] st_part = word_reg & ((32'h1 << st_bits) - 32'h1);
    wire [31:0] st_left = st_part << (6'h20 - st_bits);
    wire [15:0] own_pos = st_left[31:16];
    always_ff @(posedge CLK)
    begin
        if (SRST) word_reg <= '0;
        else if (link_reg == LINK_DONE) word_reg <= dec_word;
    end

    // Scaled source; the 16-bit source rolls over so the scaled count does too
    wire [15:0] src = own_src_reg ? own_pos : SRC_VALUE;
    wire [15:0] den_safe = (den_reg == 16'h0000) ? SIM_SCALE_RST : den_reg;
    wire [31:0] scaled = (32'(src) * 32'(num_reg)) / 32'(den_safe);
    logic [15:0] scaled_reg, out_cnt_reg, step_cnt_reg;
    logic fd_pulse_reg;
    wire [15:0] delta = scaled_reg - out_cnt_reg;
    wire step_tick = step_cnt_reg >= 16'(STEP_CYC - 1);

    // One count per step tick (one quadrature edge, or one SIM_A pulse in frequency and direction mode) keeps the output rate bounded; large jumps lag
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            scaled_reg <= '0;
            out_cnt_reg <= '0;
            step_cnt_reg <= '0;
            fd_pulse_reg <= 1'b0;
            SIM_A <= 1'b0;
            SIM_B <= 1'b0;
        end
        else
        begin
            scaled_reg <= scaled[15:0];
            step_cnt_reg <= step_tick ? 16'h0000 : step_cnt_reg + 16'h0001;
            if (step_tick && delta != 16'h0000)
                out_cnt_reg <= delta[15] ? out_cnt_reg - 16'h0001 : out_cnt_reg + 16'h0001;
            fd_pulse_reg <= step_tick && delta != 16'h0000;
            if (cfg_reg.sim_mode == SIM_FREQ_DIR)
            begin
                SIM_A <= fd_pulse_reg;
                if (step_tick && delta != 16'h0000) SIM_B <= !delta[15];
            end
            else
            begin
                SIM_A <= out_cnt_reg[1];
                SIM_B <= out_cnt_reg[1] ^ out_cnt_reg[0];
            end
        end
    end

    // Read mux and read channel; one cycle from address to data
    wire ra_ok = ra == REG_CTRL || ra == REG_TURNS || ra == REG_LINES || ra == REG_DIVIDER
        || ra == REG_SIM_SRC || ra == REG_SIM_NUM || ra == REG_SIM_DEN || ra == REG_EFF_LINES
        || ra == REG_STATUS || ra == REG_POSITION || ra == REG_COMMS_RES || ra == REG_CMD;
    wire [31:0] status = {16'h0000, 1'b0, total_bits, ibits, 2'h0, overspeed_reg,
        link_reg != LINK_IDLE};
    wire [31:0] rd_mux = (ra == REG_CTRL) ? 32'(cfg_reg)
        : (ra == REG_TURNS) ? 32'(turns_reg)
        : (ra == REG_LINES) ? 32'(lines_reg)
        : (ra == REG_DIVIDER) ? 32'(divider_reg)
        : (ra == REG_SIM_SRC) ? {15'h0000, own_src_reg, 3'h0, SRC_SEL[10:6], 2'h0, SRC_SEL[5:0]}
        : (ra == REG_SIM_NUM) ? 32'(num_reg)
        : (ra == REG_SIM_DEN) ? 32'(den_reg)
        : (ra == REG_EFF_LINES) ? eff_lines_reg
        : (ra == REG_STATUS) ? status
        : (ra == REG_POSITION) ? {rev_count, own_pos}
        : (ra == REG_COMMS_RES) ? 32'(comms_res_reg) : 32'h0000_0000;
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= RESP_OK;
        end
        else if (ARVALID && ARREADY)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_mux;
            RRESP <= ra_ok ? RESP_OK : RESP_ERR;
        end
        else if (RVALID && RREADY)
        begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end
endmodule : ssef_top

// *** testbench/ssef_props.sv ***
// Port-level checker for the encoder feedback and simulated output block
module ssef_props
    import ssef_pkg::*;
#(
    parameter int STEP_CYC = 2
) (
    input logic CLK, // Clock
    input logic SRST, // Reset
    input logic AWVALID, // AW valid
    input logic AWREADY, // AW ready
    input logic WVALID, // W valid
    input logic WREADY, // W ready
    input logic [1:0] BRESP, // B response
    input logic BVALID, // B valid
    input logic BREADY, // B ready
    input logic ARVALID, // AR valid
    input logic ARREADY, // AR ready
    input logic [31:0] RDATA, // Read data
    input logic RVALID, // R valid
    input logic RREADY, // R ready
    input logic ENC_CLK, // Link clock
    input logic [10:0] SRC_SEL, // Source index
    input logic SIM_A, // Output A
    input logic SIM_B // Output B
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LO_MIN = 24;
    localparam int LO_MAX = 501;
    int lo_cnt;
    int gap;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // Low-phase length of the link clock and spacing of output steps
    always_ff @(posedge CLK)
    begin
        lo_cnt <= (SRST || ENC_CLK) ? 0 : lo_cnt + 1;
        gap <= (SRST || $changed({SIM_A, SIM_B})) ? 0 : gap + 1;
    end
    a_quad_single_edge: assert property ($changed(SIM_A) |-> $stable(SIM_B))
        else $error("both simulated channels changed at once");
    // Steps are paced by the step timer, never faster
    a_quad_step_gap: assert property ($changed({SIM_A, SIM_B}) |-> gap >= STEP_CYC - 1)
        else $error("simulated output stepped too soon");
    a_reset_state: assert property ($fell(SRST) |-> ENC_CLK && !SIM_A && !SIM_B && SRC_SEL == 11'h000)
        else $error("outputs not at rest after reset");
    a_src_sel_range: assert property (SRC_SEL[10:6] <= MENU_MAX && SRC_SEL[5:0] <= PARAM_MAX)
        else $error("source index out of range");
    a_link_half_period: assert property ($rose(ENC_CLK) |-> lo_cnt inside {[LO_MIN:LO_MAX]})
        else $error("link clock low phase outside baud range");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> !BVALID ##1 BVALID)
        else $error("write response not two cycles after take");
    a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped before taken");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data not one cycle after take");
    a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped before taken");
endmodule : ssef_props

bind ssef_top ssef_props #(.STEP_CYC(STEP_CYC)) u_props (
    .CLK(CLK), .SRST(SRST), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .ENC_CLK(ENC_CLK), .SRC_SEL(SRC_SEL),
    .SIM_A(SIM_A), .SIM_B(SIM_B)
);

// *** testbench/ssef_enc_model.sv ***
// Behavioural absolute encoder answering on the synchronous serial link
module ssef_enc_model (
    input logic enc_clk, // Link clock from the block
    input logic [31:0] word, // Position word to send
    input logic [5:0] nbits, // Word width in bits
    output logic data // Serial data to the block
);
    timeunit 1ns;
    timeprecision 1ns;
    int left = 0;
    initial data = 1'b1;
    // New bit on each fall, MSB first, so it is settled a half period before the rise
    always @(negedge enc_clk)
    begin
        if (left == 0)
            left = nbits;
        data = word[left - 1];
    end
    // Last bit held past the sampling delay, then the line no longer shows it
    always @(posedge enc_clk)
    begin
        if (left > 0)
            left = left - 1;
        if (left == 0)
        begin
            #200;
            data = ~data;
        end
    end
endmodule : ssef_enc_model

// *** testbench/ssef_top_bench.sv ***
// Register-level testbench of the encoder feedback block
module ssef_top_bench
    import ssef_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic sin_sq = 1'b0;
    logic [2:0] amp_level = 3'h0;
    logic [15:0] src_value = 16'h0;
    logic [5:0] nbits = 6'h4;
    logic [31:0] enc_word = 32'h0;
    logic [15:0] qcnt = 16'h0;
    logic [1:0] ph_prev = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, enc_clk, enc_data, sim_a, sim_b;
    logic [1:0] bresp, rresp, resp, ph;
    logic [31:0] rdata, rd;
    logic [31:0] pos [2];
    logic [10:0] src_sel;
    int n_mismatch = 0;
    int checks = 0;
    int lo_run = 0, lo_len = 0, rises = 0, sin_half = 1000, i, n;
    logic [7:0] rst_addr [8] = '{REG_CTRL, REG_TURNS, REG_LINES, REG_DIVIDER, REG_SIM_SRC, REG_SIM_NUM,
                                 REG_SIM_DEN, REG_COMMS_RES};
    logic [31:0] rst_val [8] = '{32'h0, 32'h0, 32'h400, 32'h1, 32'h10000, 32'h1, 32'h1, 32'h19};
    logic [31:0] eff_exp [4] = '{32'h80, 32'h40, 32'h40, 32'h80};
    int amp_t [4] = '{4, 4, 1, 0};
    int per_t [4] = '{600, 3000, 700, 1500};
    logic [3:0] bits_t [4] = '{4'h8, 4'h9, 4'hA, 4'hB};

    ssef_top #(.STEP_CYC(2)) DUT (
        .CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready), .ENC_CLK(enc_clk), .ENC_DATA(enc_data), .SIN_SQ(sin_sq),
        .AMP_LEVEL(amp_level), .SRC_SEL(src_sel), .SRC_VALUE(src_value), .SIM_A(sim_a), .SIM_B(sim_b)
    );
    ssef_enc_model u_enc (.enc_clk(enc_clk), .word(enc_word), .nbits(nbits), .data(enc_data));

    initial forever #5 clk = ~clk;
    // Squared sine track with a settable half period
    initial forever
    begin
        repeat (sin_half) @(posedge clk);
        sin_sq <= ~sin_sq;
    end
    // Quadrature decoder and link clock watcher; counts wrap like the source
    always @(posedge clk)
    begin
        ph = {sim_a, sim_a ^ sim_b};
        if (ph - ph_prev == 2'h1) qcnt = qcnt + 16'h1;
        if (ph - ph_prev == 2'h3) qcnt = qcnt - 16'h1;
        ph_prev = ph;
        if (enc_clk === 1'b0) lo_run++;
        if (enc_clk === 1'b1 && lo_run != 0) rises++;
        if (enc_clk === 1'b1 && lo_run != 0) lo_len = lo_run;
        if (enc_clk === 1'b1) lo_run = 0;
    end

    task finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Both channels offered together, response ready raised once it shows
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        if (n == 200) n_mismatch++;
        if (n == 200) finish_test();
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task axi_read(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        if (n == 200) n_mismatch++;
        if (n == 200) finish_test();
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_read
    // One frame on the link, polled until the busy flag drops
    task serial_read;
        int k;
        rises = 0;
        axi_write(REG_CMD, 32'h1);
        for (k = 0; k < 100; k++)
        begin
            axi_read(REG_STATUS);
            if (rd[0] === 1'b0) break;
            repeat (50) @(posedge clk);
        end
        if (k == 100) n_mismatch++;
        if (k == 100) finish_test();
    endtask : serial_read
    task wait_quad(input logic [15:0] e);
        for (n = 0; n < 3000 && qcnt !== e; n++) @(posedge clk);
        check("simulated count", {16'h0, qcnt}, {16'h0, e});
        if (n == 3000) finish_test();
    endtask : wait_quad

    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 8; i++)
        begin
            axi_read(rst_addr[i]);
            check("reset value", rd, rst_val[i]);
        end
        axi_read(8'h30);
        check("unmapped read", {rd[31:2], resp}, {30'h0, RESP_ERR});
        axi_write(8'h30, 32'h1);
        check("unmapped write", {30'h0, resp}, {30'h0, RESP_ERR});
        // Source index at the top corner, then two out-of-range writes
        axi_write(REG_SIM_SRC, 32'h1533);
        check("source select", {21'h0, src_sel}, 32'h573);
        axi_write(REG_SIM_SRC, 32'h1600);
        axi_write(REG_SIM_SRC, 32'h1534);
        axi_read(REG_SIM_SRC);
        check("source kept", rd, 32'h1533);
        src_value <= 16'h0064;
        wait_quad(16'h0064);
        axi_write(REG_SIM_NUM, 32'h3);
        axi_write(REG_SIM_DEN, 32'h2);
        wait_quad(16'h0096);
        axi_write(REG_SIM_NUM, 32'h1);
        axi_write(REG_SIM_DEN, 32'h1);
        src_value <= 16'hFFF0;
        wait_quad(16'hFFF0);
        // Non-integer line count over every feedback type
        axi_write(REG_LINES, 32'd128123);
        axi_write(REG_DIVIDER, 32'd1000);
        for (i = 0; i < 4; i++)
        begin
            axi_write(REG_CTRL, 32'(i) << 3);
            axi_read(REG_EFF_LINES);
            check("effective lines", rd, eff_exp[i]);
        end
        axi_write(REG_DIVIDER, 32'h0);
        axi_read(REG_EFF_LINES);
        check("zero divider", rd, 32'd128123);
        axi_write(REG_COMMS_RES, 32'h4);
        for (i = 0; i < 5; i++)
        begin
            axi_write(REG_CTRL, (32'(i) << 5) | 32'h1);
            serial_read();
            check("link rises", 32'(rises), 32'h4);
            check("link half period", 32'(lo_len), 32'(CLK_HZ / (2 * BAUD_HZ[i])));
        end
        axi_write(REG_COMMS_RES, 32'h10);
        axi_write(REG_TURNS, 32'h2);
        nbits = 6'h10;
        enc_word = 32'h8000;
        for (i = 0; i < 2; i++)
        begin
            axi_write(REG_CTRL, 32'h80 | 32'(1 - i));
            serial_read();
            axi_read(REG_POSITION);
            pos[i] = rd;
            check("position word", rd, (i == 0) ? 32'h0002_0000 : 32'h0003_FFFC);
        end
        check("gray decode", {31'h0, pos[0][15:0] != pos[1][15:0]}, 32'h1);
        for (i = 0; i < 4; i++)
        begin
            amp_level <= 3'(amp_t[i]);
            sin_half = per_t[i] / 2;
            repeat (4 * per_t[i]) @(posedge clk);
            axi_read(REG_STATUS);
            check("interp bits", {28'h0, rd[7:4]}, {28'h0, bits_t[i]});
            check("total bits", {25'h0, rd[14:8]}, 32'(bits_t[i]) + 32'd17);
            check("overspeed", {31'h0, rd[1]}, {31'h0, i == 0});
        end
        finish_test();
    end
endmodule : ssef_top_bench
